//--- rtl/bsp_pkg.sv
// Purpose: shared constants for the burst sram port
// Assumes: organisations of 8, 18 or 36 data bits
// Notes:   all pin-level figures live here
package bsp_pkg;
  localparam int BSP_BURST_LEN = 4;
  localparam int BSP_ORG_X8    = 8;
  localparam int BSP_ORG_X18   = 18;
  localparam int BSP_ORG_X36   = 36;
  localparam int BSP_LANE_NARROW = 4;
  localparam int BSP_LANE_WIDE   = 9;
  localparam int BSP_UPPER_X8  = 19;
  localparam int BSP_UPPER_X18 = 18;
  localparam int BSP_UPPER_X36 = 17;
  localparam logic [1:0] BSP_START_X8 = 2'h0;
  localparam logic [1:0] BSP_LAST_BEAT = 2'h3;
  localparam logic BSP_DIR_READ = 1'h1;

  typedef enum {BSP_IDLE, BSP_BURST} bsp_state_t;

  function automatic int bsp_lane_w(input int dw);
    return (dw == BSP_ORG_X8) ? BSP_LANE_NARROW : BSP_LANE_WIDE;
  endfunction

  function automatic int bsp_upper_w(input int dw);
    return (dw == BSP_ORG_X8)  ? BSP_UPPER_X8 :
           (dw == BSP_ORG_X18) ? BSP_UPPER_X18 : BSP_UPPER_X36;
  endfunction
endpackage

//--- rtl/bsp_beat_if.sv
// Purpose: carries loads and beats between port and sequencer
// Assumes: one clock, strobes one cycle wide
// Notes:   beat fields are combinational from the sequencer
`timescale 1ns/100ps
interface bsp_beat_if #(parameter int UPPER_W = 17);
  logic               load_req;
  logic               load_read;
  logic [UPPER_W-1:0] load_upper;
  logic [1:0]         load_start;
  logic               wr_edge;
  logic               rd_edge;
  logic               beat_valid;
  logic               beat_read;
  logic [UPPER_W+1:0] beat_addr;
  logic               busy;
  logic [1:0]         beat_idx;

  modport seq (input load_req, load_read, load_upper, load_start,
               input wr_edge, rd_edge,
               output beat_valid, beat_read, beat_addr, busy, beat_idx);
  modport port (output load_req, load_read, load_upper, load_start,
                output wr_edge, rd_edge,
                input beat_valid, beat_read, beat_addr, busy, beat_idx);
endinterface

//--- rtl/bsp_burst_seq.sv
// Purpose: four-beat burst sequencer with one pending load
// Assumes: loads arrive on positive input clock edges only
// Notes:   a second load while one is pending replaces it
`timescale 1ns/100ps
module bsp_burst_seq
  import bsp_pkg::*;
#(
  parameter int UPPER_W = 17
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // beat carrier
  bsp_beat_if.seq   bus
);
  bsp_state_t         state;
  logic               cur_read;
  logic [UPPER_W-1:0] cur_upper;
  logic [1:0]         cur_start;
  logic [1:0]         idx;
  logic               pend_valid;
  logic               pend_read;
  logic [UPPER_W-1:0] pend_upper;
  logic [1:0]         pend_start;
  logic [2:0]         beats_seen;
  wire                active;
  wire                beat;
  wire                finishing;
  wire                free;

  assign active    = (state == BSP_BURST);
  assign beat      = active & (cur_read ? bus.rd_edge : bus.wr_edge);
  assign finishing = beat & (idx == BSP_LAST_BEAT);
  assign free      = !active | finishing;

  assign bus.beat_valid = beat;
  assign bus.beat_read  = cur_read;
  assign bus.busy       = active;
  assign bus.beat_idx   = idx;
  assign bus.beat_addr  = {cur_upper, 2'(cur_start + idx)};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= BSP_IDLE;
      cur_read   <= 1'h0;
      cur_upper  <= '0;
      cur_start  <= 2'h0;
      idx        <= 2'h0;
      pend_valid <= 1'h0;
      pend_read  <= 1'h0;
      pend_upper <= '0;
      pend_start <= 2'h0;
    end else begin
      case (state)
        BSP_IDLE,
        BSP_BURST: begin
          if (free) begin
            idx <= 2'h0;
            if (pend_valid) begin
              state      <= BSP_BURST;
              cur_read   <= pend_read;
              cur_upper  <= pend_upper;
              cur_start  <= pend_start;
              pend_valid <= bus.load_req;
            end else if (bus.load_req) begin
              state     <= BSP_BURST;
              cur_read  <= bus.load_read;
              cur_upper <= bus.load_upper;
              cur_start <= bus.load_start;
            end else begin
              state <= BSP_IDLE;
            end
          end else begin
            if (beat) begin
              idx <= 2'(idx + 2'h1);
            end
            if (bus.load_req) begin
              pend_valid <= 1'h1;
            end
          end
          if (bus.load_req) begin
            pend_read  <= bus.load_read;
            pend_upper <= bus.load_upper;
            pend_start <= bus.load_start;
          end
        end
        default: state <= BSP_IDLE;
      endcase
    end
  end

  // beats of the running burst, counted apart from idx
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      beats_seen <= 3'h0;
    end else if (free) begin
      beats_seen <= 3'h0;
    end else if (beat) begin
      beats_seen <= 3'(beats_seen + 3'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_wrap_four;
    beat && idx == BSP_LAST_BEAT |=> idx == 2'h0;
  endproperty
  a_wrap_four: assert property (p_wrap_four)
    else $error("burst index did not wrap after fourth beat");

  property p_load_dir;
    free && !pend_valid && bus.load_req
      |=> active && cur_read == $past(bus.load_read)
          && cur_start == $past(bus.load_start);
  endproperty
  a_load_dir: assert property (p_load_dir)
    else $error("loaded direction or start not taken");

  property p_addr_ignored;
    active && !free |=> $stable(cur_upper) && $stable(cur_start);
  endproperty
  a_addr_ignored: assert property (p_addr_ignored)
    else $error("address changed while burst running");

  property p_four_beats;
    finishing |-> beats_seen == 3'(BSP_BURST_LEN - 1) && $past(active);
  endproperty
  a_four_beats: assert property (p_four_beats)
    else $error("burst ended before four beats");
endmodule // bsp_burst_seq

//--- rtl/bsp_sram_port.sv
// Purpose: device side of a four-word burst ddr sram port
// Assumes: pin clocks are levels synchronous to clk
// Notes:   array held here, no reset on its contents
`timescale 1ns/100ps
module bsp_sram_port
  import bsp_pkg::*;
#(
  parameter int DATA_W  = BSP_ORG_X36,
  parameter int LANE_W  = bsp_lane_w(DATA_W),
  parameter int LANES   = DATA_W / LANE_W,
  parameter int UPPER_W = bsp_upper_w(DATA_W)
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // link clocks from controller
  input  wire logic               input_clk,
  input  wire logic               input_clk_b,
  input  wire logic               out_clk,
  input  wire logic               out_clk_b,
  input  wire logic               single_clock_mode,
  // transaction control
  input  wire logic               transaction_load_n,
  input  wire logic               read_not_write,
  input  wire logic [UPPER_W-1:0] addr_upper,
  input  wire logic               burst_start_bit0,
  input  wire logic               burst_start_bit1,
  input  wire logic [LANES-1:0]   byte_lane_write_sel_n,
  // shared data pins
  input  wire logic [DATA_W-1:0]  dq_in,
  output      logic [DATA_W-1:0]  dq_out,
  output      logic               dq_oe,
  // echo clocks
  output      logic               echo_clock,
  output      logic               echo_clock_b
);
  localparam int MEM_AW = UPPER_W + 2;

  bsp_beat_if #(.UPPER_W(UPPER_W)) bus ();

  logic              k_prev;
  logic              kb_prev;
  logic              c_prev;
  logic              cb_prev;
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic [MEM_AW-1:0] last_addr;
  wire               k_rise;
  wire               kb_rise;
  wire               c_rise;
  wire               cb_rise;
  wire               rd_beat;
  wire               wr_beat;
  wire [DATA_W-1:0]  rd_word;
  wire [DATA_W-1:0]  merged;

  assign k_rise  = input_clk & ~k_prev;
  assign kb_rise = input_clk_b & ~kb_prev;
  assign c_rise  = out_clk & ~c_prev;
  assign cb_rise = out_clk_b & ~cb_prev;

  assign bus.wr_edge    = k_rise | kb_rise;
  assign bus.rd_edge    = single_clock_mode ? (k_rise | kb_rise)
                                            : (c_rise | cb_rise);
  assign bus.load_req   = k_rise & ~transaction_load_n;
  assign bus.load_read  = (read_not_write == BSP_DIR_READ);
  assign bus.load_upper = addr_upper;
  assign bus.load_start = (DATA_W == BSP_ORG_X8) ? BSP_START_X8
                        : {burst_start_bit1, burst_start_bit0};

  bsp_burst_seq #(.UPPER_W(UPPER_W)) u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .bus     (bus)
  );

  assign rd_beat = bus.beat_valid & bus.beat_read;
  assign wr_beat = bus.beat_valid & ~bus.beat_read;
  assign rd_word = mem[bus.beat_addr];

  // per-lane merge: lane width 4 or 9 gives the lane maps
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign merged[i*LANE_W +: LANE_W] = byte_lane_write_sel_n[i]
      ? rd_word[i*LANE_W +: LANE_W]
      : dq_in[i*LANE_W +: LANE_W];
  end

  always_ff @(posedge clk) begin
    if (wr_beat) begin
      mem[bus.beat_addr] <= merged;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      k_prev  <= 1'h0;
      kb_prev <= 1'h0;
      c_prev  <= 1'h0;
      cb_prev <= 1'h0;
    end else begin
      k_prev  <= input_clk;
      kb_prev <= input_clk_b;
      c_prev  <= out_clk;
      cb_prev <= out_clk_b;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_out <= '0;
      dq_oe  <= 1'h0;
    end else if (rd_beat) begin
      dq_out <= rd_word;
      dq_oe  <= 1'h1;
    end else if (bus.rd_edge) begin
      dq_oe  <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      echo_clock   <= 1'h0;
      echo_clock_b <= 1'h0;
    end else begin
      echo_clock   <= single_clock_mode ? input_clk : out_clk;
      echo_clock_b <= single_clock_mode ? input_clk_b : out_clk_b;
    end
  end

  // address of the previous beat, kept for the linear burst check
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_addr <= '0;
    end else if (bus.beat_valid) begin
      last_addr <= bus.beat_addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_release;
    !bus.busy && bus.rd_edge |=> !dq_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data drivers on while read not selected");

  property p_launch;
    rd_beat |=> dq_oe && dq_out == $past(rd_word);
  endproperty
  a_launch: assert property (p_launch)
    else $error("read word not launched on output edge");

  property p_lane_write;
    wr_beat && !byte_lane_write_sel_n[0]
      |=> mem[$past(bus.beat_addr)][LANE_W-1:0]
          == $past(dq_in[LANE_W-1:0]);
  endproperty
  a_lane_write: assert property (p_lane_write)
    else $error("selected lane not written");

  property p_lane_keep;
    wr_beat && byte_lane_write_sel_n[LANES-1]
      |=> mem[$past(bus.beat_addr)][DATA_W-1 -: LANE_W]
          == $past(rd_word[DATA_W-1 -: LANE_W]);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("deselected lane was altered");

  property p_beat_on_edge;
    bus.beat_valid |-> (bus.beat_read ? bus.rd_edge : bus.wr_edge);
  endproperty
  a_beat_on_edge: assert property (p_beat_on_edge)
    else $error("beat without its clock edge");

  property p_echo;
    !single_clock_mode ##1 !$past(single_clock_mode)
      |-> echo_clock == $past(out_clk);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo clock not following output clock");

  property p_linear;
    bus.beat_valid && bus.beat_idx != 2'h0
      |-> bus.beat_addr == {last_addr[MEM_AW-1:2],
                            2'(last_addr[1:0] + 2'h1)};
  endproperty
  a_linear: assert property (p_linear)
    else $error("burst word address not linear");

  property p_start_on_k;
    $rose(bus.busy) |-> $past(k_rise && !transaction_load_n);
  endproperty
  a_start_on_k: assert property (p_start_on_k)
    else $error("burst began without a load on input clock rise");

  property p_oe_from_read;
    $rose(dq_oe) |-> $past(rd_beat);
  endproperty
  a_oe_from_read: assert property (p_oe_from_read)
    else $error("data drivers enabled outside a read beat");

  property p_narrow_start;
    $rose(bus.busy) && DATA_W == BSP_ORG_X8
      |-> bus.beat_addr[1:0] == BSP_START_X8;
  endproperty
  a_narrow_start: assert property (p_narrow_start)
    else $error("byte organisation burst not starting at zero");

  property p_echo_b;
    !$past(single_clock_mode) |-> echo_clock_b == $past(out_clk_b);
  endproperty
  a_echo_b: assert property (p_echo_b)
    else $error("complement echo clock not following output clock");
endmodule // bsp_sram_port

//--- verif/bsp_ctrl_model.sv
// Purpose: controller side clock source for the burst sram port bench
// Assumes: pin clock levels change 1 ns after clk, pairs kept opposite, out pair low while out_run is low
// Notes:   slow halves the pin rate; clocks stand low while in reset
`timescale 1ns/100ps
module bsp_ctrl_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // rate and output pair enable
  input  wire logic slow,
  input  wire logic out_run,
  // pin clocks
  output      logic input_clk,
  output      logic input_clk_b,
  output      logic out_clk,
  output      logic out_clk_b,
  // hints: a pair edge, or a positive input edge, follows this clk
  output      logic edge_next,
  output      logic k_next
);
  logic [2:0] ph;
  logic       run;
  logic       lvl;

  assign lvl = slow ? ph[2] : ph[1];
  assign edge_next = run & (slow ? (ph[1:0] == 2'h3) : ph[0]);
  assign k_next = edge_next & ~lvl;
  assign input_clk = run & lvl;
  assign input_clk_b = run & ~lvl;
  assign out_clk = run & out_run & lvl;
  assign out_clk_b = run & out_run & ~lvl;

  always @(posedge clk) begin
    run <= #1 reset_n;
    ph <= #1 run ? ph + 3'h1 : 3'h0;
  end
endmodule // bsp_ctrl_model

//--- verif/burst_sram_port_pins_tb.sv
// Purpose: self-checking bench for the burst sram port, x36 and x8 builds
// Assumes: one burst at a time, pin clocks from the controller model
// Notes:   memory model is an associative array of words
`timescale 1ns/100ps
module burst_sram_port_pins_tb;
  import bsp_pkg::*;
  localparam int DW = BSP_ORG_X36;
  localparam int UW = 4;
  localparam int LN = 4;
  localparam int LW = BSP_LANE_WIDE;
  localparam int NW = BSP_LANE_NARROW;
  localparam int D8 = BSP_ORG_X8;
  logic          clk, reset_n, slow, out_run, single_clock_mode;
  logic          input_clk, input_clk_b, out_clk, out_clk_b;
  logic          edge_next, k_next, transaction_load_n, read_not_write;
  logic          b0, b1, dq_oe, echo_clock, echo_clock_b, oc_p, ocb_p;
  logic [UW-1:0] addr_upper;
  logic [LN-1:0] sel_n;
  logic [DW-1:0] dq_in, dq_out;
  logic [DW-1:0] mem [int];
  logic [DW-1:0] rq [$];
  logic [D8-1:0] dq_out8;
  logic [D8-1:0] mem8 [int];
  logic [D8-1:0] rq8 [$];
  logic          dq_oe8, echo8, echob8;
  logic [2:0]    es;
  int            n_fail, n_compared, rd_left, seed;

  bsp_ctrl_model ctrl_u (.clk(clk), .reset_n(reset_n), .slow(slow),
    .out_run(out_run), .input_clk(input_clk), .input_clk_b(input_clk_b),
    .out_clk(out_clk), .out_clk_b(out_clk_b), .edge_next(edge_next),
    .k_next(k_next));
  bsp_sram_port #(.DATA_W(DW), .UPPER_W(UW)) dut_u (.clk(clk),
    .reset_n(reset_n), .input_clk(input_clk), .input_clk_b(input_clk_b),
    .out_clk(out_clk), .out_clk_b(out_clk_b),
    .single_clock_mode(single_clock_mode),
    .transaction_load_n(transaction_load_n),
    .read_not_write(read_not_write), .addr_upper(addr_upper),
    .burst_start_bit0(b0), .burst_start_bit1(b1),
    .byte_lane_write_sel_n(sel_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .echo_clock(echo_clock), .echo_clock_b(echo_clock_b));
  bsp_sram_port #(.DATA_W(D8), .UPPER_W(UW)) dut8_u (.clk(clk),
    .reset_n(reset_n), .input_clk(input_clk), .input_clk_b(input_clk_b),
    .out_clk(out_clk), .out_clk_b(out_clk_b),
    .single_clock_mode(single_clock_mode),
    .transaction_load_n(transaction_load_n),
    .read_not_write(read_not_write), .addr_upper(addr_upper),
    .burst_start_bit0(b0), .burst_start_bit1(b1),
    .byte_lane_write_sel_n(sel_n[1:0]), .dq_in(dq_in[D8-1:0]),
    .dq_out(dq_out8), .dq_oe(dq_oe8), .echo_clock(echo8),
    .echo_clock_b(echob8));

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for a pair edge (k: positive input edge only)
  task automatic wait_hint(input bit k);
    int i;
    for (i = 0; i < 32; i++) begin
      @(posedge clk);
      if (edge_next && (!k || k_next)) break;
    end
    if (i == 32) begin
      n_fail++;
      stop_test();
    end else #1;
  endtask

  task automatic burst(input bit rd, input logic [UW-1:0] up,
                       input logic [1:0] st, input bit part);
    logic [DW-1:0] d;
    logic [DW-1:0] w;
    logic [LN-1:0] s;
    logic [D8-1:0] w8;
    int            a;
    int            a8;
    wait_hint(1);
    transaction_load_n = 0;
    read_not_write = rd;
    addr_upper = up;
    {b1, b0} = st;
    if (rd) begin
      for (int i = 0; i < BSP_BURST_LEN; i++) begin
        rq.push_back(mem[{up, 2'(st + i)}]);
        rq8.push_back(mem8[{up, 2'(i)}]);
      end
      rd_left = BSP_BURST_LEN;
    end
    for (int i = 0; i < BSP_BURST_LEN; i++) begin
      wait_hint(0);
      transaction_load_n = 1;
      addr_upper = UW'($urandom);
      {b1, b0} = 2'($urandom);
      a = {up, 2'(st + i)};
      a8 = {up, 2'(i)};
      d = DW'({$urandom, $urandom});
      s = part ? LN'($urandom) : '0;
      dq_in = d;
      sel_n = s;
      if (!rd) begin
        chk(dq_oe, 0);
        w = mem.exists(a) ? mem[a] : 'x;
        for (int l = 0; l < LN; l++)
          if (!s[l]) w[l*LW +: LW] = d[l*LW +: LW];
        mem[a] = w;
        chk(dq_oe8, 0);
        w8 = mem8.exists(a8) ? mem8[a8] : 'x;
        for (int l = 0; l < 2; l++)
          if (!s[l]) w8[l*NW +: NW] = d[l*NW +: NW];
        mem8[a8] = w8;
      end
    end
  endtask

  // read beats tracked so data is checked 2.5 clk after its edge
  always @(posedge clk) begin
    es <= {es[1:0], edge_next && rd_left != 0};
    if (edge_next && rd_left != 0) rd_left--;
    oc_p <= single_clock_mode ? input_clk : out_clk;
    ocb_p <= single_clock_mode ? input_clk_b : out_clk_b;
  end

  always @(negedge clk) if (reset_n) begin
    chk(echo_clock, oc_p);
    chk(echo_clock_b, ocb_p);
    chk(echo8, oc_p);
    chk(echob8, ocb_p);
    if (es[2]) begin
      chk(dq_oe, 1);
      chk(dq_out, rq.pop_front());
      chk(dq_oe8, 1);
      chk(dq_out8, rq8.pop_front());
    end
  end

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    {n_fail, n_compared, rd_left, es} = '0;
    {slow, single_clock_mode, read_not_write, b0, b1} = '0;
    {reset_n, addr_upper, dq_in} = '0;
    {transaction_load_n, out_run, sel_n} = '1;
    repeat (16) @(posedge clk);
    #1 reset_n = 1;
    seed = $urandom(29257);
    chk(dq_oe, 0);
    // fast, slow, single clock, single clock slow
    for (int m = 0; m < 4; m++) begin
      slow = m[0];
      single_clock_mode = m[1];
      out_run = !m[1];
      for (int u = 0; u < 3; u++) begin
        burst(0, UW'(m * 3 + u), 2'h0, 0);
        burst(0, UW'(m * 3 + u), 2'($urandom), 1);
        burst(1, UW'(m * 3 + u), 2'($urandom), 0);
      end
      repeat (8) @(posedge clk);
      #1 chk(dq_oe, 0);
      chk(dq_oe8, 0);
      $display("test mode %0d done", m);
    end
    stop_test();
  end
endmodule // burst_sram_port_pins_tb
